// ==== sfw_device.sv ====
// device end: boot protocol interpreter for the flash write command
// Behaviour
// - wait for 5AH, then run 9600 bps
// - echo 5AH back as first byte
// - unrecognised match byte: silent, retry detection
// - controller sends baud code, 28H unchanged
// - echo valid baud code, then switch rate
// - bad baud code: A1H,A3H,62H thrice, halt
// - write command 30H echoed when valid
// - bad command: A1H,A3H,63H thrice, halt
// - count address bytes taken silently
// - comparison address bytes taken silently
// - receive error in password phase halts
// - compare N password bytes, mismatch halts
// - blank product skips password compare
// - read protection or password error halts
// - no echo, discard until 3AH mark
// - parse record, write payload to flash
// - receive or record error halts silently
// - send checksum upper then lower byte
// - checksum only after clean end record
// - after checksum, wait for next command
// - controller must not write only FFE0H-FFFFH
// - controller erases before rewriting
`timescale 1ns/10ps
`include "sfw_defs.svh"
module sfw_device #(
  parameter logic [39:0] BAUD_CODES = 40'h28_18_20_30_38,
  parameter logic [4:0] BAUD_OK_MASK = 5'h1f
) (
  input wire logic ref_clk,
  input wire logic rst,
  sfw_link_if.device link,
  input wire logic readProtect,
  output logic [15:0] memAddr,
  input wire logic [7:0] memRdData,
  output logic memWrEn,
  output logic [7:0] memWrData,
  output logic halted,
  output logic [2:0] baudSelOut
);
  import sfw_pkg::*;
  typedef enum logic [10:0] {
    ST_MATCH = 11'h001, ST_BAUD = 11'h002, ST_CMD = 11'h004, ST_ADDR = 11'h008,
    ST_BLANK = 11'h010, ST_CNT = 11'h020, ST_PWD = 11'h040, ST_MARK = 11'h080,
    ST_REC = 11'h100, ST_SUM = 11'h200, ST_HALT = 11'h400
  } sfw_state_type;
  sfw_state_type state;
  logic [2:0] baudSel;
  logic [2:0] pendBaud;
  logic pendSwitch;
  logic [1:0] addrIdx;
  sfw_addr_type cntAddr;
  sfw_addr_type cmpAddr;
  sfw_byte_type pwdLeft;
  logic blankOk;
  logic [5:0] scanIdx;
  logic [2:0] recField;
  sfw_byte_type recLen;
  sfw_addr_type recAddr;
  sfw_addr_type wrAddr;
  sfw_byte_type recType;
  sfw_byte_type recSum;
  logic [15:0] totalSum;
  logic sumHigh;
  // transmit fifo path: error code queue counters
  logic [3:0] errCnt;
  sfw_byte_type errCode;
  logic txValid;
  sfw_byte_type txData;
  logic txReady;

  function automatic sfw_byte_type err_byte(input logic [3:0] n, input sfw_byte_type code);
    err_byte = (n > 4'd6) ? `SFW_ERR_LEAD0 : (n > 4'd3) ? `SFW_ERR_LEAD1 : code;
  endfunction

  // decoding of incoming bytes
  wire rxTake = link.hostValid && (state != ST_HALT) && (state != ST_SUM)
                && (errCnt == 4'd0) && txReady && !pendSwitch
                && (state != ST_BLANK) && (state != ST_CNT);
  wire sfw_byte_type rxByte = link.hostData;
  wire rxErr = link.hostRxError;
  logic baudHit;
  logic [2:0] baudIdx;
  always_comb begin
    baudHit = 1'b0;
    baudIdx = 3'd0;
    for (int i = 0; i < 5; i++) begin
      if (BAUD_CODES[39-8*i -: 8] == rxByte && BAUD_OK_MASK[4-i]) begin
        baudHit = 1'b1;
        baudIdx = 3'(i);
      end
    end
  end
  assign link.hostReady = rxTake || (state == ST_HALT);
  assign link.baudSel = baudSel;
  assign baudSelOut = baudSel;
  assign halted = (state == ST_HALT) && (errCnt == 4'd0);
  // a pending flash write keeps the address its data byte arrived with
  assign memAddr = memWrEn ? wrAddr
                 : (state == ST_BLANK) ? (`SFW_BLANK_LO + 16'(scanIdx[4:0]))
                 : (state == ST_CNT) ? cntAddr : (state == ST_PWD) ? cmpAddr : recAddr;

  sfw_fifo #(.WIDTH(8), .DEPTH(8)) txFifo (
    .ref_clk(ref_clk), .rst(rst),
    .inValid(txValid), .inReady(txReady), .inData(txData),
    .outValid(link.devValid), .outReady(link.devReady), .outData(link.devData)
  );

  // protocol sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_MATCH;
      baudSel <= 3'd0;
      pendBaud <= 3'd0;
      pendSwitch <= 1'b0;
      addrIdx <= 2'd0;
      cntAddr <= '0;
      cmpAddr <= '0;
      pwdLeft <= '0;
      blankOk <= 1'b1;
      scanIdx <= '0;
      recField <= '0;
      recLen <= '0;
      recAddr <= '0;
      wrAddr <= '0;
      recType <= '0;
      recSum <= '0;
      totalSum <= '0;
      sumHigh <= 1'b1;
      errCnt <= '0;
      errCode <= '0;
      txValid <= 1'b0;
      txData <= '0;
      memWrEn <= 1'b0;
      memWrData <= '0;
    end else begin
      txValid <= 1'b0;
      memWrEn <= 1'b0;
      if (pendSwitch && !link.devValid && !txValid) begin
        baudSel <= pendBaud;
        pendSwitch <= 1'b0;
      end
      if (errCnt != 4'd0 && txReady && !txValid) begin // one push in flight, none lost
        txValid <= 1'b1;
        txData <= err_byte(errCnt, errCode);
        errCnt <= errCnt - 4'd1;
      end
      case (state)
        ST_MATCH: begin
          if (rxTake && !rxErr && rxByte == `SFW_MATCH_BYTE) begin
            baudSel <= 3'd0;
            txValid <= 1'b1;
            txData <= `SFW_MATCH_BYTE;
            state <= ST_BAUD;
          end
        end // other bytes dropped silently
        ST_BAUD: begin
          if (rxTake) begin
            if (baudHit && !rxErr) begin
              txValid <= 1'b1;
              txData <= rxByte;
              pendBaud <= baudIdx;
              pendSwitch <= 1'b1;
              state <= ST_CMD;
            end else begin
              errCnt <= 4'd9;
              errCode <= `SFW_ERR_BAUD;
              state <= ST_HALT;
            end
          end
        end
        ST_CMD: begin
          if (rxTake) begin
            if (rxByte == `SFW_CMD_WRITE && !rxErr) begin
              txValid <= 1'b1;
              txData <= rxByte;
              addrIdx <= 2'd0;
              state <= readProtect ? ST_HALT : ST_ADDR;
            end else begin
              errCnt <= 4'd9;
              errCode <= `SFW_ERR_CMD;
              state <= ST_HALT;
            end
          end
        end
        ST_ADDR: begin
          if (rxTake) begin
            if (rxErr) begin
              state <= ST_HALT;
            end else begin
              addrIdx <= addrIdx + 2'd1;
              case (addrIdx)
                2'd0: cntAddr[15:8] <= rxByte;
                2'd1: cntAddr[7:0] <= rxByte;
                2'd2: cmpAddr[15:8] <= rxByte;
                default: cmpAddr[7:0] <= rxByte;
              endcase
              if (addrIdx == 2'd3) begin
                scanIdx <= '0;
                blankOk <= 1'b1;
                state <= ST_BLANK;
              end
            end
          end
        end
        ST_BLANK: begin
          // scan the top 32 bytes for the blank pattern
          if (memRdData != `SFW_BLANK_BYTE) begin
            blankOk <= 1'b0;
          end
          scanIdx <= scanIdx + 6'd1;
          if (scanIdx == 6'd31) begin
            state <= (blankOk && memRdData == `SFW_BLANK_BYTE) ? ST_MARK : ST_CNT;
          end
        end
        ST_CNT: begin
          pwdLeft <= memRdData;
          state <= (memRdData == 8'h00) ? ST_MARK : ST_PWD;
        end
        ST_PWD: begin
          if (rxTake) begin
            if (rxErr || rxByte != memRdData) begin
              state <= ST_HALT;
            end else begin
              cmpAddr <= cmpAddr + 16'd1;
              pwdLeft <= pwdLeft - 8'd1;
              if (pwdLeft == 8'd1) begin
                state <= ST_MARK;
              end
            end
          end
        end
        ST_MARK: begin
          if (rxTake && rxErr) begin
            state <= ST_HALT;
          end else if (rxTake && rxByte == `SFW_START_MARK) begin
            recField <= 3'd0;
            recSum <= '0;
            state <= ST_REC;
          end
        end
        ST_REC: begin
          if (rxTake) begin
            recSum <= recSum + rxByte;
            if (rxErr) begin
              state <= ST_HALT;
            end else begin
              case (recField)
                3'd0: begin
                  recLen <= rxByte;
                  recField <= 3'd1;
                end
                3'd1: begin
                  recAddr[15:8] <= rxByte;
                  recField <= 3'd2;
                end
                3'd2: begin
                  recAddr[7:0] <= rxByte;
                  recField <= 3'd3;
                end
                3'd3: begin
                  recType <= rxByte;
                  recField <= (recLen == 8'h00) ? 3'd5 : 3'd4;
                  if (rxByte != `SFW_REC_DATA && rxByte != `SFW_REC_END) begin
                    state <= ST_HALT;
                  end
                end
                3'd4: begin
                  memWrEn <= 1'b1;
                  memWrData <= rxByte;
                  wrAddr <= recAddr;
                  totalSum <= totalSum + 16'(rxByte);
                  recAddr <= recAddr + 16'd1;
                  recLen <= recLen - 8'd1;
                  recField <= (recLen == 8'd1) ? 3'd5 : 3'd4;
                end
                default: begin
                  if (8'(recSum + rxByte) != 8'h00) begin
                    state <= ST_HALT;
                  end else if (recType == `SFW_REC_END) begin
                    sumHigh <= 1'b1;
                    state <= ST_SUM;
                  end else begin
                    state <= ST_MARK;
                  end
                end
              endcase
            end
          end
        end
        ST_SUM: begin
          if (txReady && errCnt == 4'd0 && !txValid) begin
            txValid <= 1'b1;
            txData <= sumHigh ? totalSum[15:8] : totalSum[7:0];
            sumHigh <= 1'b0;
            if (!sumHigh) begin
              totalSum <= '0;
              state <= ST_CMD;
            end
          end
        end
        ST_HALT: begin
          state <= ST_HALT;
        end
        default: state <= ST_HALT;
      endcase
    end
  end
endmodule

// ==== sfw_defs.svh ====
// constants for the serial flash write protocol
`ifndef SFW_DEFS_SVH
`define SFW_DEFS_SVH
`define SFW_MATCH_BYTE 8'h5a
`define SFW_BAUD_INIT 8'h28
`define SFW_CMD_WRITE 8'h30
`define SFW_ERR_LEAD0 8'ha1
`define SFW_ERR_LEAD1 8'ha3
`define SFW_ERR_BAUD 8'h62
`define SFW_ERR_CMD 8'h63
`define SFW_START_MARK 8'h3a
`define SFW_REC_DATA 8'h00
`define SFW_REC_END 8'h01
`define SFW_BLANK_BYTE 8'hff
`define SFW_BLANK_LO 16'hffe0
`define SFW_ERR_REPEAT 2'd3
`define SFW_BAUD_BPS 9600
`define SFW_CLK_HZ 10000000
`define SFW_BIT_CYCLES (`SFW_CLK_HZ / `SFW_BAUD_BPS)
`endif

// ==== sfw_pkg.sv ====
// types for the serial flash write protocol
package sfw_pkg;
  typedef logic [7:0] sfw_byte_type;
  typedef logic [15:0] sfw_addr_type;
endpackage

// ==== sfw_fifo.sv ====
// parameterised fifo on the data path
`timescale 1ns/10ps
module sfw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;
  // honest full and empty from the count
  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  // pointer and count update
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        mem[wrPtr] <= inData;
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule

// ==== sfw_link_if.sv ====
// byte link between programming controller and device
`timescale 1ns/10ps
interface sfw_link_if;
  logic [7:0] hostData;
  logic hostValid;
  logic hostReady;
  logic hostRxError;
  logic [7:0] devData;
  logic devValid;
  logic devReady;
  logic [2:0] baudSel;
  modport device (
    input hostData, hostValid, hostRxError, devReady,
    output hostReady, devData, devValid, baudSel
  );
  modport host (
    output hostData, hostValid, hostRxError, devReady,
    input hostReady, devData, devValid, baudSel
  );
endinterface

// ==== sfw_host.sv ====
// host end: programming controller driving one write session
`timescale 1ns/10ps
`include "sfw_defs.svh"
module sfw_host (
  input wire logic ref_clk,
  input wire logic rst,
  sfw_link_if.host link,
  input wire logic start,
  input wire logic [7:0] baudCode,
  input wire logic [7:0] streamData,
  input wire logic streamValid,
  output logic streamReady,
  output logic busy,
  output logic done,
  output logic failed,
  output logic [15:0] checksum
);
  import sfw_pkg::*;
  typedef enum logic [5:0] {
    H_IDLE = 6'h01, H_MATCH = 6'h02, H_BAUD = 6'h04, H_CMD = 6'h08,
    H_STREAM = 6'h10, H_SUM = 6'h20
  } sfw_hstate_type;
  sfw_hstate_type state;
  logic sentOne;
  logic sumHigh;
  sfw_byte_type txByte;
  logic txHave;
  // sending side of the link
  assign link.hostData = (state == H_STREAM) ? streamData : txByte;
  assign link.hostValid = (state == H_STREAM) ? streamValid : txHave;
  assign link.hostRxError = 1'b0;
  assign link.devReady = 1'b1;
  assign streamReady = (state == H_STREAM) && link.hostReady;
  assign busy = (state != H_IDLE);
  wire rxGot = link.devValid;
  // session sequencer; stream ends when the upper checksum byte arrives, whatever the caller still feeds
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= H_IDLE;
      sentOne <= 1'b0;
      sumHigh <= 1'b1;
      txByte <= '0;
      txHave <= 1'b0;
      done <= 1'b0;
      failed <= 1'b0;
      checksum <= '0;
    end else begin
      done <= 1'b0;
      if (txHave && link.hostReady) begin
        txHave <= 1'b0;
      end
      case (state)
        H_IDLE: begin
          if (start) begin
            failed <= 1'b0;
            sentOne <= 1'b0;
            state <= H_MATCH;
          end
        end
        H_MATCH: begin
          // one match byte only: a second would be taken as the baud code
          if (!txHave && !sentOne) begin
            txByte <= `SFW_MATCH_BYTE;
            txHave <= 1'b1;
            sentOne <= 1'b1;
          end
          if (rxGot && link.devData == `SFW_MATCH_BYTE) begin
            txByte <= baudCode;
            txHave <= 1'b1;
            state <= H_BAUD;
          end
        end
        H_BAUD: begin
          if (rxGot) begin
            if (link.devData == baudCode) begin
              txByte <= `SFW_CMD_WRITE;
              txHave <= 1'b1;
              state <= H_CMD;
            end else begin
              failed <= 1'b1;
              state <= H_IDLE;
            end
          end
        end
        H_CMD: begin
          if (rxGot) begin
            failed <= (link.devData != `SFW_CMD_WRITE);
            state <= (link.devData == `SFW_CMD_WRITE) ? H_STREAM : H_IDLE;
          end
        end
        H_STREAM: begin
          // addresses, password, records come from the caller
          if (rxGot) begin
            checksum[15:8] <= link.devData;
            sumHigh <= 1'b0;
            state <= H_SUM;
          end
        end
        H_SUM: begin
          if (rxGot) begin
            checksum[7:0] <= link.devData;
            done <= 1'b1;
            sumHigh <= 1'b1;
            state <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule

// ==== sfw_link_chk.sv ====
// assertions on the joined controller to device link
`timescale 1ns/10ps
module sfw_link_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] hostData,
  input wire logic hostValid,
  input wire logic hostReady,
  input wire logic hostRxError,
  input wire logic [7:0] devData,
  input wire logic devValid,
  input wire logic devReady,
  input wire logic [2:0] baudSel
);
  import sfw_pkg::*;
  logic [2:0] hostCnt;
  logic [2:0] devCnt;
  wire hostTake = hostValid && hostReady;
  wire devTake = devValid && devReady;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // saturating counts of bytes taken each way
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hostCnt <= 3'h0;
      devCnt <= 3'h0;
    end else begin
      if (hostTake && hostCnt != 3'h7) hostCnt <= hostCnt + 3'h1;
      if (devTake && devCnt != 3'h7) devCnt <= devCnt + 3'h1;
    end
  end
  // handshake holds and the byte order of one session
  host_hold_a: assert property (hostValid && !hostReady |=> hostValid && $stable(hostData))
    else $error("host byte changed before taken");
  dev_hold_a: assert property (devValid && !devReady |=> devValid && $stable(devData))
    else $error("device byte changed before taken");
  match_first_a:
    assert property (hostTake && hostCnt == 3'h0 |-> hostData == 8'h5a)
    else $error("first host byte is not the match byte");
  match_echo_a:
    assert property (hostTake && hostCnt == 3'h0 |-> ##[2:8] (devValid && devData == 8'h5a))
    else $error("match byte not echoed in time");
  rate_hold_a: assert property (devCnt < 3'h2 |-> baudSel == 3'h0)
    else $error("rate switched before the baud echo");
  cmd_send_a:
    assert property (hostTake && hostCnt == 3'h2 |-> hostData == 8'h30)
    else $error("third host byte is not the write command");
  cmd_echo_a: assert property (devTake && devCnt == 3'h2 |-> devData == 8'h30)
    else $error("third device byte is not the command echo");
  dev_quiet_a: assert property (devTake |-> devCnt < 3'h5)
    else $error("device sent more than five bytes");
endmodule

// ==== sfw_tb.sv ====
// testbench: controller joined to device, and a bench-driven device
`timescale 1ns/10ps
module sfw_tb;
  import sfw_pkg::*;
  localparam logic [39:0] CODES = 40'h28_18_20_30_38;
  logic ref_clk, rst, rstB, start, readProtect, streamValid, streamReady, busy, done, failed;
  logic memWrA, memWrB, haltA, haltB, drainOn;
  sfw_byte_type baudCode, streamData, wrA, wrB;
  sfw_addr_type checksum, addrA, addrB;
  logic [2:0] selA, selB;
  sfw_byte_type memA [0:65535];
  sfw_byte_type memB [0:65535];
  sfw_byte_type devQ [$];
  sfw_addr_type sumQ [$];
  int failures, totalChecks;
  // blank part: addresses, a two-byte record at 1000h, the end record
  sfw_byte_type pairBytes [18] = '{8'hff, 8'he0, 8'hff, 8'he1, 8'h3a, 8'h02, 8'h10, 8'h00,
    8'h00, 8'haa, 8'h55, 8'hef, 8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff};
  sfw_link_if linkA ();
  sfw_link_if linkB ();
  // controller and device joined, a second device, the checker
  sfw_host sfw_host_i (.ref_clk(ref_clk), .rst(rst), .link(linkA.host), .start(start),
    .baudCode(baudCode), .streamData(streamData), .streamValid(streamValid),
    .streamReady(streamReady), .busy(busy), .done(done), .failed(failed), .checksum(checksum));
  sfw_device sfw_device_i (.ref_clk(ref_clk), .rst(rst), .link(linkA.device),
    .readProtect(1'b0), .memAddr(addrA), .memRdData(memA[addrA]), .memWrEn(memWrA),
    .memWrData(wrA), .halted(haltA), .baudSelOut(selA));
  sfw_device #(.BAUD_CODES(CODES), .BAUD_OK_MASK(5'h1f)) sfw_device_b_i (.ref_clk(ref_clk),
    .rst(rstB), .link(linkB.device), .readProtect(readProtect), .memAddr(addrB),
    .memRdData(memB[addrB]), .memWrEn(memWrB), .memWrData(wrB), .halted(haltB),
    .baudSelOut(selB));
  sfw_link_chk sfw_link_chk_i (.ref_clk(ref_clk), .rst(rst), .hostData(linkA.hostData),
    .hostValid(linkA.hostValid), .hostReady(linkA.hostReady), .hostRxError(linkA.hostRxError),
    .devData(linkA.devData), .devValid(linkA.devValid), .devReady(linkA.devReady),
    .baudSel(linkA.baudSel));
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // flash models and random stalls of the second device's reader
  always @(posedge ref_clk) begin
    if (memWrA === 1'b1) memA[addrA] <= wrA;
    if (memWrB === 1'b1) memB[addrB] <= wrB;
  end
  always @(negedge ref_clk) begin
    linkB.devReady <= drainOn && (($urandom % 4) != 0);
  end
  // each result seen takes the oldest note of its kind
  always @(posedge ref_clk) begin
    if (linkB.devValid === 1'b1 && linkB.devReady === 1'b1)
      cmp("devData", pop(devQ), {8'h00, linkB.devData});
    if (done === 1'b1) begin
      cmp("checksum", sumQ.pop_front(), checksum);
      cmp("failed", 16'h0000, {15'h0000, failed});
    end
  end
  function automatic sfw_addr_type pop(ref sfw_byte_type q[$]);
    return q.size() != 0 ? {8'h00, q.pop_front()} : 16'h0100;
  endfunction
  task automatic cmp(input string what, input sfw_addr_type expVal, input sfw_addr_type seen);
    totalChecks++;
    if (seen !== expVal) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, expVal, seen);
    end
  endtask
  task automatic note(input sfw_byte_type b, input int n = 1);
    repeat (n) devQ.push_back(b);
  endtask
  task automatic fault(input sfw_byte_type code);
    note(8'ha1, 3);
    note(8'ha3, 3);
    note(code, 3);
  endtask
  // holds the byte until taken; the next send or idle changes it
  task automatic send(input sfw_byte_type b, input logic err = 1'b0);
    linkB.hostData = b;
    linkB.hostRxError = err;
    linkB.hostValid = 1'b1;
    #1;
    for (int i = 0; i < 900 && linkB.hostReady !== 1'b1; i++) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic idle();
    linkB.hostValid = 1'b0;
    linkB.hostRxError = 1'b0;
    linkB.hostData = ~linkB.hostData;
  endtask
  task automatic settle();
    for (int i = 0; i < 5000 && devQ.size() + sumQ.size() != 0; i++)
      @(negedge ref_clk);
    repeat (40) @(negedge ref_clk);
  endtask
  task automatic resetB(input logic prot);
    @(negedge ref_clk);
    readProtect = prot;
    rstB = 1'b1;
    foreach (memB[a]) memB[a] = 8'hff;
    repeat (2) @(negedge ref_clk);
    rstB = 1'b0;
  endtask
  task automatic hello(input sfw_byte_type code, input sfw_byte_type cmd, input logic codeOk);
    note(8'h5a);
    send(8'h55);
    send(8'h5a);
    if (codeOk) note(code);
    else fault(8'h62);
    send(code);
    if (codeOk) begin
      if (cmd == 8'h30) note(8'h30);
      else fault(8'h63);
      send(cmd);
    end
  endtask
  task automatic addrs(input sfw_addr_type cnt, input sfw_addr_type cmpAt);
    send(cnt[15:8]);
    send(cnt[7:0]);
    send(cmpAt[15:8]);
    send(cmpAt[7:0]);
  endtask
  task automatic rec(input sfw_addr_type addr, input sfw_byte_type kind, input sfw_byte_type d);
    sfw_byte_type len;
    len = (kind == 8'h00) ? 8'h01 : 8'h00;
    send(8'h3a);
    send(len);
    send(addr[15:8]);
    send(addr[7:0]);
    send(kind);
    if (len != 8'h00) send(d);
    send(8'h00 - (len + addr[15:8] + addr[7:0] + kind + ((len != 8'h00) ? d : 8'h00)));
  endtask
  task automatic body();
    sfw_byte_type d;
    d = 8'($urandom);
    note(8'h00);
    note(d);
    send(8'h00);
    rec(16'h2000, 8'h00, d);
    rec(16'h0000, 8'h01, 8'h00);
    idle();
    settle();
    cmp("memB 2000h", {8'h00, d}, {8'h00, memB[16'h2000]});
  endtask
  task automatic closeCase(input string name, input logic expHalt);
    idle();
    settle();
    cmp("halted", {15'h0000, expHalt}, {15'h0000, haltB});
    $display("test %s finished", name);
  endtask
  task automatic finish_test();
    $display("checks %0d, failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // cuts a hang short
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
  // main sequence
  initial begin
    {start, readProtect, streamValid, drainOn, rst, rstB} = 6'h07;
    {linkB.hostValid, linkB.hostRxError, linkB.devReady} = 3'h1;
    {linkB.hostData, streamData, baudCode} = 24'h00_0028;
    void'($urandom(32));
    baudCode = CODES[39 - 8 * ($urandom % 5) -: 8];
    foreach (memA[a]) memA[a] = 8'hff;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    rstB = 1'b0;
    sumQ.push_back(16'h00ff);
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    foreach (pairBytes[k]) begin
      streamData = pairBytes[k];
      streamValid = 1'b1;
      #1;
      for (int i = 0; i < 5000 && streamReady !== 1'b1; i++) @(negedge ref_clk);
      @(negedge ref_clk);
    end
    streamValid = 1'b0;
    settle();
    cmp("memA 1000h", 16'h00aa, {8'h00, memA[16'h1000]});
    cmp("memA 1001h", 16'h0055, {8'h00, memA[16'h1001]});
    $display("test joined session finished");
    for (int i = 0; i < 5; i++) begin
      resetB(1'b0);
      hello(CODES[39 - 8 * i -: 8], 8'h30, 1'b1);
      if (i == 4) begin
        addrs(16'hffe0, 16'hffe1);
        body();
        note(8'h30);
        send(8'h30);
      end
      closeCase("baud code", 1'b0);
      cmp("baudSel", 16'(i), {13'h0000, linkB.baudSel});
    end
    for (int w = 0; w < 2; w++) begin
      resetB(1'b0);
      memB[16'hffe0] = 8'h02;
      memB[16'hffe1] = 8'h12;
      memB[16'hffe2] = 8'h34;
      hello(8'h28, 8'h30, 1'b1);
      addrs(16'hffe0, 16'hffe1);
      send(8'h12);
      send((w != 0) ? 8'h35 : 8'h34);
      if (w == 0) body();
      closeCase("password", w[0]);
    end
    // bad baud with the reader stalled: nine error bytes meet an eight-deep fifo
    resetB(1'b0);
    note(8'h5a);
    send(8'h5a);
    idle();
    settle();
    drainOn = 1'b0;
    @(negedge ref_clk);
    fault(8'h62);
    send(8'h11);
    repeat (40) @(negedge ref_clk);
    cmp("fifo refuses", 16'h0000, {15'h0000, haltB});
    cmp("fifo full", 16'h0001, {15'h0000, linkB.devValid});
    drainOn = 1'b1;
    closeCase("bad baud", 1'b1);
    cmp("fifo empty", 16'h0000, {15'h0000, linkB.devValid});
    resetB(1'b0);
    hello(8'h28, 8'h77, 1'b1);
    closeCase("bad command", 1'b1);
    resetB(1'b0);
    hello(8'h28, 8'h30, 1'b1);
    send(8'hff, 1'b1);
    closeCase("receive error", 1'b1);
    resetB(1'b1);
    hello(8'h28, 8'h30, 1'b1);
    addrs(16'hffe0, 16'hffe1);
    closeCase("read protect", 1'b1);
    resetB(1'b0);
    hello(8'h28, 8'h30, 1'b1);
    addrs(16'hffe0, 16'hffe1);
    rec(16'h0000, 8'h05, 8'h00);
    closeCase("bad record", 1'b1);
    finish_test();
  end
endmodule
